// ### vtr_regs.sv
/*
 * vtr_regs: register group for sync timing, subcarrier word and phase,
 * caption bytes, blanking-line enables, teletext request edges and
 * copy control, with decoded control outputs for the encoder core.
 * assumes: the serial bus slave presents one-cycle write strobes and a
 * subaddress synchronous to clk_i; read data is registered.
 */
`timescale 1ns/1ps

// Notes on behaviour
// [R1] sync timing adjust at 08H, read and write
// [R2] bits 1:0 set master hsync width
// [R3] bits 3:2 shift hsync versus field/vsync
// [R4] mode 1: bits 5:4 hsync to field rise
// [R5] mode 2: bits 5:4 set vsync width
// [R6] bits 7:6 hsync versus pixel data
// [R7] 09H-0CH hold 32-bit subcarrier increment
// [R8] lowest frequency byte resets to 16h
// [R9] phase at 0DH, 1.41 degrees per step
// [R10] even field caption bytes at 0EH/0FH
// [R11] odd field caption bytes at 10H/11H
// [R12] 12H-15H one bit per blanking line
// [R13] ntsc: set bit kills pedestal on line
// [R14] pal: set bit enables teletext on line
// [R15] upper nibble at 19H: request rise 0-15
// [R16] lower nibble: request fall 0-15 clocks
// [R17] fall nibble zero: fall tracks rise; code sets fall to new rise minus previous rise, per write, not cumulative
// [R18] copy bits 3:0 are cgms tail only
// [R19] bit 4 selects internal cgms crc
// [R20] bits 5/6 cgms odd/even, ntsc only
// [R21] bit 7 wss enable, pal only
// [R22] shared data bits: cgms ntsc, wss pal
// [R23] lowest subaddress is increment lsb
module vtr_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic addr_hit_o,
  // encoder state
  input wire logic pal_mode_i,
  input wire logic [1:0] timing_mode_i,
  // sync timing controls
  output logic [1:0] hsync_width_o,
  output logic [1:0] hsync_to_vsync_o,
  output logic [1:0] hsync_to_field_rise_o,
  output logic [1:0] vsync_width_o,
  output logic [1:0] hsync_to_pixel_o,
  // subcarrier
  output logic [31:0] subcarrier_incr_o,
  output logic [7:0] subcarrier_phase_o,
  // closed caption
  output logic [15:0] caption_even_data_o,
  output logic [15:0] caption_odd_data_o,
  // blanking line controls
  output logic [15:0] pedestal_even_lines_o,
  output logic [15:0] pedestal_odd_lines_o,
  output logic [15:0] teletext_even_lines_o,
  output logic [15:0] teletext_odd_lines_o,
  // teletext request window
  output logic [3:0] teletext_rise_o,
  output logic [3:0] teletext_fall_o,
  // copy generation and wide screen
  output logic [3:0] cgms_tail_o,
  output logic cgms_crc_internal_o,
  output logic cgms_odd_en_o,
  output logic cgms_even_en_o,
  output logic wss_en_o,
  output logic shared_is_cgms_o
);

  logic rst_sync1_q;
  logic rst_sync2_q;
  logic rst_n;

  logic [7:0] sync_timing_adjust_q;
  logic [7:0] freq_q [4];
  logic [7:0] subcarrier_phase_q;
  logic [7:0] cap_even_q [2];
  logic [7:0] cap_odd_q [2];
  logic [7:0] line_q [4];
  logic [7:0] copy_control_0_q;
  logic [7:0] teletext_request_edges_q;
  logic [3:0] fall_offset_q;
  logic [7:0] rdata_q;
  logic rvalid_q;

  logic wr_sync;
  logic wr_phase;
  logic wr_copy;
  logic wr_ttx;
  logic [7:0] rdata_d;
  logic hit;

  // true when the subaddress lies within base .. base+n-1
  function automatic logic in_range(input logic [7:0] a,
                                    input logic [7:0] base,
                                    input logic [7:0] n);
    in_range = (a >= base) && (a < base + n);
  endfunction : in_range

  // reset release through two flops
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end
    else
    begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= rst_sync1_q;
    end
  end
  assign rst_n = rst_sync2_q;

  assign wr_sync = wr_en_i && (addr_i == vtr_pkg::SA_SYNC_ADJ);
  assign wr_phase = wr_en_i && (addr_i == vtr_pkg::SA_PHASE);
  assign wr_copy = wr_en_i && (addr_i == vtr_pkg::SA_COPY0);
  assign wr_ttx = wr_en_i && (addr_i == vtr_pkg::SA_TTX_EDGES);

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      sync_timing_adjust_q <= vtr_pkg::RST_ZERO;
    else if (wr_sync)
      sync_timing_adjust_q <= wdata_i; // [R1]
  end

  // frequency bytes; byte 0 sits at the lowest subaddress
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      freq_q[0] <= vtr_pkg::RST_FREQ0; // [R8]
      freq_q[1] <= vtr_pkg::RST_ZERO;
      freq_q[2] <= vtr_pkg::RST_ZERO;
      freq_q[3] <= vtr_pkg::RST_ZERO;
    end
    else if (wr_en_i && in_range(addr_i, vtr_pkg::SA_FREQ0, 8'h04))
      freq_q[2'(addr_i - vtr_pkg::SA_FREQ0)] <= wdata_i; // [R7]
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      subcarrier_phase_q <= vtr_pkg::RST_PHASE;
    else if (wr_phase)
      subcarrier_phase_q <= wdata_i; // [R9]
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap_even_q[0] <= vtr_pkg::RST_ZERO;
      cap_even_q[1] <= vtr_pkg::RST_ZERO;
    end
    else if (wr_en_i && in_range(addr_i, vtr_pkg::SA_CAP_EVEN0, 8'h02))
      cap_even_q[addr_i[0] ^ vtr_pkg::SA_CAP_EVEN0[0]] <= wdata_i; // [R10]
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap_odd_q[0] <= vtr_pkg::RST_ZERO;
      cap_odd_q[1] <= vtr_pkg::RST_ZERO;
    end
    else if (wr_en_i && in_range(addr_i, vtr_pkg::SA_CAP_ODD0, 8'h02))
      cap_odd_q[addr_i[0] ^ vtr_pkg::SA_CAP_ODD0[0]] <= wdata_i; // [R11]
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_q[0] <= vtr_pkg::RST_ZERO;
      line_q[1] <= vtr_pkg::RST_ZERO;
      line_q[2] <= vtr_pkg::RST_ZERO;
      line_q[3] <= vtr_pkg::RST_ZERO;
    end
    else if (wr_en_i && in_range(addr_i, vtr_pkg::SA_LINE0, 8'h04))
      line_q[2'(addr_i - vtr_pkg::SA_LINE0)] <= wdata_i; // [R12]
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      copy_control_0_q <= vtr_pkg::RST_ZERO;
    else if (wr_copy)
      copy_control_0_q <= wdata_i;
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      teletext_request_edges_q <= vtr_pkg::RST_ZERO;
    else if (wr_ttx)
      teletext_request_edges_q <= wdata_i; // [R15] [R16]
  end

  // fall offset latched while the fall nibble is zero, so a later
  // rise change sets the fall edge to the new rise minus the previous rise
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      fall_offset_q <= 4'h0;
    else if (wr_ttx &&
             (teletext_request_edges_q[vtr_pkg::TTX_FALL_LSB +: 4] == 4'h0))
      fall_offset_q <= 4'(wdata_i[vtr_pkg::TTX_RISE_LSB +: 4] -
                          teletext_request_edges_q[vtr_pkg::TTX_RISE_LSB +: 4]);
    else if (wr_ttx)
      fall_offset_q <= 4'h0;
  end

  // read path
  always_comb
  begin
    rdata_d = 8'h00;
    hit = 1'b1;
    unique case (addr_i)
      vtr_pkg::SA_SYNC_ADJ: rdata_d = sync_timing_adjust_q;
      vtr_pkg::SA_FREQ0: rdata_d = freq_q[0];
      vtr_pkg::SA_FREQ1: rdata_d = freq_q[1];
      vtr_pkg::SA_FREQ2: rdata_d = freq_q[2];
      vtr_pkg::SA_FREQ3: rdata_d = freq_q[3];
      vtr_pkg::SA_PHASE: rdata_d = subcarrier_phase_q;
      vtr_pkg::SA_CAP_EVEN0: rdata_d = cap_even_q[0];
      vtr_pkg::SA_CAP_EVEN1: rdata_d = cap_even_q[1];
      vtr_pkg::SA_CAP_ODD0: rdata_d = cap_odd_q[0];
      vtr_pkg::SA_CAP_ODD1: rdata_d = cap_odd_q[1];
      vtr_pkg::SA_LINE0: rdata_d = line_q[0];
      vtr_pkg::SA_LINE1: rdata_d = line_q[1];
      vtr_pkg::SA_LINE2: rdata_d = line_q[2];
      vtr_pkg::SA_LINE3: rdata_d = line_q[3];
      vtr_pkg::SA_COPY0: rdata_d = copy_control_0_q;
      vtr_pkg::SA_TTX_EDGES: rdata_d = teletext_request_edges_q;
      default: hit = 1'b0;
    endcase
  end

  // unmapped subaddresses read as zero
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= rd_en_i;
      if (rd_en_i)
        rdata_q <= rdata_d; // [R1]
    end
  end

  assign rdata_o = rdata_q;
  assign rvalid_o = rvalid_q;
  assign addr_hit_o = hit;

  // sync timing decode
  assign hsync_width_o =
    sync_timing_adjust_q[vtr_pkg::HS_WIDTH_LSB +: 2]; // [R2]
  assign hsync_to_vsync_o =
    sync_timing_adjust_q[vtr_pkg::HS_TO_VS_LSB +: 2]; // [R3]
  assign hsync_to_field_rise_o =
    (timing_mode_i == vtr_pkg::TIMING_MODE_1) ?
    sync_timing_adjust_q[vtr_pkg::HS_FIELD_LSB +: 2] : 2'h0; // [R4]
  assign vsync_width_o =
    (timing_mode_i == vtr_pkg::TIMING_MODE_2) ?
    sync_timing_adjust_q[vtr_pkg::HS_FIELD_LSB +: 2] : 2'h0; // [R5]
  // applies in master and slave alike
  assign hsync_to_pixel_o =
    sync_timing_adjust_q[vtr_pkg::HS_PIXEL_LSB +: 2]; // [R6]

  assign subcarrier_incr_o =
    {freq_q[3], freq_q[2], freq_q[1], freq_q[0]}; // [R7] [R23]
  assign subcarrier_phase_o = subcarrier_phase_q; // [R9]

  assign caption_even_data_o = {cap_even_q[1], cap_even_q[0]}; // [R10]
  assign caption_odd_data_o = {cap_odd_q[1], cap_odd_q[0]}; // [R11]

  // same bits mean pedestal-off in ntsc, teletext-on in pal
  assign pedestal_even_lines_o =
    pal_mode_i ? 16'h0000 : {line_q[1], line_q[0]}; // [R13]
  assign pedestal_odd_lines_o =
    pal_mode_i ? 16'h0000 : {line_q[3], line_q[2]}; // [R13]
  assign teletext_even_lines_o =
    pal_mode_i ? {line_q[1], line_q[0]} : 16'h0000; // [R14]
  assign teletext_odd_lines_o =
    pal_mode_i ? {line_q[3], line_q[2]} : 16'h0000; // [R14]

  assign teletext_rise_o =
    teletext_request_edges_q[vtr_pkg::TTX_RISE_LSB +: 4]; // [R15]
  // nonzero fall nibble is used as written
  assign teletext_fall_o =
    (teletext_request_edges_q[vtr_pkg::TTX_FALL_LSB +: 4] == 4'h0) ?
    fall_offset_q :
    teletext_request_edges_q[vtr_pkg::TTX_FALL_LSB +: 4]; // [R16] [R17]

  assign cgms_tail_o =
    copy_control_0_q[vtr_pkg::CGMS_TAIL_LSB +: 4]; // [R18]
  assign cgms_crc_internal_o = copy_control_0_q[vtr_pkg::CGMS_CRC_BIT]; // [R19]
  assign cgms_odd_en_o =
    !pal_mode_i && copy_control_0_q[vtr_pkg::CGMS_ODD_BIT]; // [R20]
  assign cgms_even_en_o =
    !pal_mode_i && copy_control_0_q[vtr_pkg::CGMS_EVEN_BIT]; // [R20]
  assign wss_en_o = pal_mode_i && copy_control_0_q[vtr_pkg::WSS_EN_BIT]; // [R21]
  assign shared_is_cgms_o = !pal_mode_i; // [R22]

endmodule : vtr_regs

// ### vtr_pkg.sv
/*
 * vtr_pkg: subaddresses, field positions and reset values for the
 * timing, subcarrier, caption, blanking-line and copy-control registers.
 * assumes: an 8-bit subaddressed register port with byte-wide data.
 */
package vtr_pkg;

  // subaddresses
  localparam logic [7:0] SA_SYNC_ADJ = 8'h08;
  localparam logic [7:0] SA_FREQ0 = 8'h09;
  localparam logic [7:0] SA_FREQ1 = 8'h0a;
  localparam logic [7:0] SA_FREQ2 = 8'h0b;
  localparam logic [7:0] SA_FREQ3 = 8'h0c;
  localparam logic [7:0] SA_PHASE = 8'h0d;
  localparam logic [7:0] SA_CAP_EVEN0 = 8'h0e;
  localparam logic [7:0] SA_CAP_EVEN1 = 8'h0f;
  localparam logic [7:0] SA_CAP_ODD0 = 8'h10;
  localparam logic [7:0] SA_CAP_ODD1 = 8'h11;
  localparam logic [7:0] SA_LINE0 = 8'h12;
  localparam logic [7:0] SA_LINE1 = 8'h13;
  localparam logic [7:0] SA_LINE2 = 8'h14;
  localparam logic [7:0] SA_LINE3 = 8'h15;
  localparam logic [7:0] SA_COPY0 = 8'h16;
  localparam logic [7:0] SA_TTX_EDGES = 8'h19;

  // sync timing adjust fields (lsb of each 2-bit field)
  localparam int HS_WIDTH_LSB = 0;
  localparam int HS_TO_VS_LSB = 2;
  localparam int HS_FIELD_LSB = 4;
  localparam int HS_PIXEL_LSB = 6;

  // copy control fields
  localparam int CGMS_TAIL_LSB = 0;
  localparam int CGMS_CRC_BIT = 4;
  localparam int CGMS_ODD_BIT = 5;
  localparam int CGMS_EVEN_BIT = 6;
  localparam int WSS_EN_BIT = 7;

  // teletext request edge nibbles
  localparam int TTX_FALL_LSB = 0;
  localparam int TTX_RISE_LSB = 4;
  localparam int TTX_DEFAULT_BITS = 360;

  // timing modes
  localparam logic [1:0] TIMING_MODE_1 = 2'h1;
  localparam logic [1:0] TIMING_MODE_2 = 2'h2;

  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_FREQ0 = 8'h16;
  localparam logic [7:0] RST_PHASE = 8'h00;

endpackage : vtr_pkg

// ### vtr_regs_checker.sv
/*
 * vtr_regs_checker: port-level properties of the register group.
 * assumes: bound into vtr_regs; ports carry the same names.
 */
`timescale 1ns/1ps
module vtr_regs_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic addr_hit_o,
  // modes
  input wire logic pal_mode_i,
  input wire logic [1:0] timing_mode_i,
  // decoded controls
  input wire logic [1:0] hsync_width_o,
  input wire logic [1:0] hsync_to_vsync_o,
  input wire logic [1:0] hsync_to_field_rise_o,
  input wire logic [1:0] vsync_width_o,
  input wire logic [1:0] hsync_to_pixel_o,
  input wire logic [31:0] subcarrier_incr_o,
  input wire logic [15:0] pedestal_even_lines_o,
  input wire logic [15:0] teletext_even_lines_o,
  input wire logic [3:0] teletext_rise_o,
  input wire logic cgms_odd_en_o,
  input wire logic wss_en_o,
  input wire logic shared_is_cgms_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_rvalid; rd_en_i |=> rvalid_o; endproperty
  a_rvalid: assert property (p_rvalid) else $error("no read answer");
  property p_unmapped; rd_en_i && !addr_hit_o |=> rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  property p_sync; wr_en_i && addr_i == 8'h08 |=>
    {hsync_to_pixel_o, hsync_to_vsync_o, hsync_width_o} ==
    {$past(wdata_i[7:6]), $past(wdata_i[3:0])}; endproperty
  a_sync: assert property (p_sync) else $error("sync fields");
  property p_mode1; timing_mode_i != 2'h1 |-> hsync_to_field_rise_o == 2'h0;
  endproperty
  a_mode1: assert property (p_mode1) else $error("field delay gate");
  property p_mode2; timing_mode_i != 2'h2 |-> vsync_width_o == 2'h0;
  endproperty
  a_mode2: assert property (p_mode2) else $error("vsync width gate");
  property p_freq; wr_en_i && addr_i == 8'h09 |=>
    subcarrier_incr_o[7:0] == $past(wdata_i); endproperty
  a_freq: assert property (p_freq) else $error("freq low byte");
  property p_pal; pal_mode_i |-> pedestal_even_lines_o == 16'h0000
    && !cgms_odd_en_o; endproperty
  a_pal: assert property (p_pal) else $error("pal gating");
  property p_ntsc; !pal_mode_i |-> teletext_even_lines_o == 16'h0000
    && !wss_en_o; endproperty
  a_ntsc: assert property (p_ntsc) else $error("ntsc gating");
  property p_rise; wr_en_i && addr_i == 8'h19 |=>
    teletext_rise_o == $past(wdata_i[7:4]); endproperty
  a_rise: assert property (p_rise) else $error("request rise");
  property p_shared; shared_is_cgms_o == !pal_mode_i; endproperty
  a_shared: assert property (p_shared) else $error("shared bits");
endmodule : vtr_regs_checker

bind vtr_regs vtr_regs_checker vtr_regs_checker_inst (.*);

// ### vtr_host.sv
/*
 * vtr_host: host model issuing strobed register reads and writes.
 * assumes: one clock shared with the register group.
 */
`timescale 1ns/1ps
module vtr_host (
  // clock
  input wire logic clk_i,
  // register port
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i
);
  initial {wr_en_o, rd_en_o, addr_o, wdata_o} = 18'h0;
  // idle data inverted so a stale byte never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_en_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_en_o <= 1'b0;
    wdata_o <= ~d;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge clk_i);
    rd_en_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_en_o <= 1'b0;
    #1;
    d = rdata_i;
    v = rvalid_i;
  endtask : rd
endmodule : vtr_host

// ### test_vtr_regs.sv
/*
 * test_vtr_regs: directed register tests for vtr_regs.
 * assumes: vtr_host drives the register port.
 */
`timescale 1ns/1ps
module test_vtr_regs;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wr_en_i, rd_en_i, rvalid_o, addr_hit_o;
  logic [7:0] addr_i, wdata_i, rdata_o, subcarrier_phase_o;
  logic pal_mode_i = 1'b0;
  logic [1:0] timing_mode_i = 2'h1;
  logic [1:0] hsync_width_o, hsync_to_vsync_o, hsync_to_field_rise_o;
  logic [1:0] vsync_width_o, hsync_to_pixel_o;
  logic [31:0] subcarrier_incr_o;
  logic [15:0] caption_even_data_o, caption_odd_data_o;
  logic [15:0] pedestal_even_lines_o, pedestal_odd_lines_o;
  logic [15:0] teletext_even_lines_o, teletext_odd_lines_o;
  logic [3:0] teletext_rise_o, teletext_fall_o, cgms_tail_o;
  logic cgms_crc_internal_o, cgms_odd_en_o, cgms_even_en_o;
  logic wss_en_o, shared_is_cgms_o;
  int num_errors = 0;
  int n_compared = 0;
  always #5 clk_i = ~clk_i;
  vtr_regs vtr_regs_inst (.*);
  vtr_host vtr_host_inst (.clk_i, .wr_en_o(wr_en_i), .rd_en_o(rd_en_i),
    .addr_o(addr_i), .wdata_o(wdata_i), .rdata_i(rdata_o),
    .rvalid_i(rvalid_o));
  function automatic logic [7:0] pat(input logic [7:0] a);
    return {a[3:0], ~a[3:0]};
  endfunction : pat
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    n_compared++;
    if (s !== e)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    vtr_host_inst.rd(a, d, v);
    chk("rvalid", 32'h1, v);
    chk("rdata", e, d);
  endtask : rc
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    #200us;
    num_errors++;
    give_verdict();
  end
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rc(8'h09, 8'h16);
    rc(8'h0d, 8'h00);
    rc(8'h07, 8'h00);
    $display("test reset done");
    for (int a = 8'h08; a <= 8'h16; a++) vtr_host_inst.wr(a, pat(a));
    vtr_host_inst.wr(8'h19, pat(8'h19));
    vtr_host_inst.wr(8'h1a, 8'hff);
    for (int a = 8'h08; a <= 8'h16; a++) rc(a, pat(a));
    rc(8'h19, 8'h96);
    rc(8'h1a, 8'h00);
    chk("incr", {pat(8'h0c), pat(8'h0b), pat(8'h0a), pat(8'h09)},
      subcarrier_incr_o);
    chk("cap_even", {pat(8'h0f), pat(8'h0e)}, caption_even_data_o);
    chk("cap_odd", {pat(8'h11), pat(8'h10)}, caption_odd_data_o);
    chk("ped_even", {pat(8'h13), pat(8'h12)}, pedestal_even_lines_o);
    chk("ped_odd", {pat(8'h15), pat(8'h14)}, pedestal_odd_lines_o);
    chk("phase", pat(8'h0d), subcarrier_phase_o);
    chk("shared_ntsc", 32'h1, shared_is_cgms_o);
    chk("cgms", 32'h96, {cgms_tail_o, cgms_crc_internal_o, cgms_odd_en_o,
      cgms_even_en_o, wss_en_o});
    @(posedge clk_i) pal_mode_i <= 1'b1;
    #1;
    chk("ttx_odd", {pat(8'h15), pat(8'h14)}, teletext_odd_lines_o);
    chk("ttx_even", {pat(8'h13), pat(8'h12)}, teletext_even_lines_o);
    chk("ped_pal", 32'h0, pedestal_odd_lines_o);
    chk("shared_pal", 32'h0, shared_is_cgms_o);
    vtr_host_inst.wr(8'h16, 8'h9f);
    chk("copy_pal", 32'hf9, {cgms_tail_o, cgms_crc_internal_o, cgms_odd_en_o,
      cgms_even_en_o, wss_en_o});
    $display("test map done");
    for (int i = 0; i < 4; i++)
      vtr_host_inst.wr(8'h09 + i, 8'(32'h21f07c1e >> (8 * i)));
    chk("ntsc_incr", 32'h21f07c1e, subcarrier_incr_o);
    vtr_host_inst.wr(8'h08, 8'he4);
    chk("sync_m1", 32'h384, {hsync_to_pixel_o, hsync_to_field_rise_o,
      vsync_width_o, hsync_to_vsync_o, hsync_width_o});
    @(posedge clk_i) timing_mode_i <= 2'h2;
    #1;
    chk("sync_m2", {hsync_to_field_rise_o, vsync_width_o}, 32'h2);
    $display("test timing done");
    vtr_host_inst.wr(8'h19, 8'h30);
    chk("ttx0", 32'h30, {teletext_rise_o, teletext_fall_o});
    vtr_host_inst.wr(8'h19, 8'h70);
    chk("ttx1", 32'h74, {teletext_rise_o, teletext_fall_o});
    vtr_host_inst.wr(8'h19, 8'h75);
    chk("ttx2", 32'h75, {teletext_rise_o, teletext_fall_o});
    $display("test teletext done");
    give_verdict();
  end
endmodule : test_vtr_regs
